/* rtl/pcf_top.v */
// Contract
// - Keep a 13-bit program counter addressing up to 8K words of 14 bits.
// - Large variant uses all 8K words; every counter value is distinct.
// - Small variant has 4K words but the same 13-bit counter.
// - Addresses above the implemented memory wrap; high bits are ignored.
// - Any reset loads the counter with address zero.
// - A taken interrupt loads the counter with address four.
// - Instruction and data memories have separate buses, usable together.
//
// Purpose: program counter and instruction fetch addressing
// Assumes: memory returns the word one cycle after fetch_req; inputs synchronous
// Notes: priority is interrupt, then branch, then increment
`timescale 1ns/1ps
`include "pcf_defs.vh"
module pcf_top #(
    parameter SMALL = 0
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Core control
    input wire step,
    input wire branch,
    input wire [12:0] branch_addr,
    input wire irq_take,
    // Data access from the core
    input wire data_req,
    input wire data_we,
    input wire [8:0] data_addr_in,
    input wire [7:0] data_wdata_in,
    // Instruction memory bus
    output wire fetch_req,
    output wire [12:0] imem_addr,
    input wire [13:0] imem_rdata,
    // Data memory bus
    output reg data_req_r,
    output reg data_we_r,
    output reg [8:0] data_addr_r,
    output reg [7:0] data_wdata_r,
    // Fetched instruction
    output reg [13:0] insn_r,
    output reg insn_valid_r,
    output reg [12:0] pc_r,
    output reg [12:0] insn_pc_r
);
    // ==========================================================
    // Declarations
    reg [12:0] pc_nxt;
    reg fetch_pend_r;
    reg fetch_pend_nxt;
    reg [12:0] fetch_pc_r;
    reg [12:0] fetch_pc_nxt;
    reg [13:0] insn_nxt;
    reg insn_valid_nxt;
    reg [12:0] insn_pc_nxt;
    reg data_req_nxt;
    reg data_we_nxt;
    reg [8:0] data_addr_nxt;
    reg [7:0] data_wdata_nxt;
    wire [12:0] phys_addr;
    wire load_irq;
    wire load_branch;
    wire advance;

    // ==========================================================
    // Load selection
    // Interrupt beats branch, branch beats a plain step
    assign load_irq = irq_take;
    assign load_branch = branch & ~irq_take;
    assign advance = step & ~irq_take & ~branch;

    // ==========================================================
    // Counter update
    always @* begin
        pc_nxt = pc_r;
        if (load_irq) begin
            pc_nxt = `PCF_INT_VEC;
        end else if (load_branch) begin
            pc_nxt = branch_addr;
        end else if (advance) begin
            // Thirteen-bit sum rolls over from the top word to zero
            pc_nxt = pc_r + `PCF_PC_STEP;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            pc_r <= `PCF_RESET_VEC;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    // ==========================================================
    // Instruction address, independent of the data bus
    pcf_wrap #(
        .SMALL(SMALL)
    ) u_wrap (
        .pc_in(pc_r),
        .addr_out(phys_addr)
    );

    assign imem_addr = phys_addr;

    // No fetch while reset holds or while the counter is reloaded
    assign fetch_req = advance & ~rst;

    // ==========================================================
    // Fetch pipeline
    always @* begin
        fetch_pend_nxt = fetch_req;
        fetch_pc_nxt = pc_r;
    end

    always @(posedge clk) begin
        if (rst) begin
            fetch_pend_r <= `PCF_FLAG_RST;
        end else begin
            fetch_pend_r <= fetch_pend_nxt;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            fetch_pc_r <= `PCF_RESET_VEC;
        end else begin
            fetch_pc_r <= fetch_pc_nxt;
        end
    end

    // ==========================================================
    // Fetched word
    // The word and its address hold until the next fetch lands
    always @* begin
        insn_valid_nxt = fetch_pend_r;
        insn_nxt = insn_r;
        insn_pc_nxt = insn_pc_r;
        if (fetch_pend_r) begin
            insn_nxt = imem_rdata;
            insn_pc_nxt = fetch_pc_r;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            insn_valid_r <= `PCF_FLAG_RST;
        end else begin
            insn_valid_r <= insn_valid_nxt;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            insn_r <= `PCF_INSN_RST;
        end else begin
            insn_r <= insn_nxt;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            insn_pc_r <= `PCF_RESET_VEC;
        end else begin
            insn_pc_r <= insn_pc_nxt;
        end
    end

    // ==========================================================
    // Data bus
    // Runs in the same cycles as fetch; shares nothing with it
    always @* begin
        data_req_nxt = data_req;
        data_we_nxt = data_req & data_we;
        data_addr_nxt = data_addr_in;
        data_wdata_nxt = data_wdata_in;
    end

    always @(posedge clk) begin
        if (rst) begin
            data_req_r <= `PCF_FLAG_RST;
        end else begin
            data_req_r <= data_req_nxt;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            data_we_r <= `PCF_FLAG_RST;
        end else begin
            data_we_r <= data_we_nxt;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            data_addr_r <= `PCF_DATA_ADDR_RST;
        end else begin
            data_addr_r <= data_addr_nxt;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            data_wdata_r <= `PCF_DATA_WDATA_RST;
        end else begin
            data_wdata_r <= data_wdata_nxt;
        end
    end
endmodule

/* common/pcf_defs.vh */
// Purpose: constants for the program counter and fetch addressing block
// Assumes: 13-bit program counter, 14-bit instruction words
// Notes: definitions only
`ifndef PCF_DEFS_VH
`define PCF_DEFS_VH
`define PCF_PC_W 13
`define PCF_INSN_W 14
`define PCF_DATA_AW 9
`define PCF_DATA_W 8
`define PCF_RESET_VEC 13'h0000
`define PCF_INT_VEC 13'h0004
`define PCF_PC_STEP 13'h0001
`define PCF_BIG_AW 13
`define PCF_SMALL_AW 12
`define PCF_FLAG_RST 1'b0
`define PCF_INSN_RST 14'h0000
`define PCF_DATA_ADDR_RST 9'h000
`define PCF_DATA_WDATA_RST 8'h00
`endif

/* rtl/pcf_wrap.v */
// Purpose: fold a program counter value onto the implemented memory
// Assumes: implemented size is a power of two
// Notes: upper bits beyond the implemented size are dropped
`timescale 1ns/1ps
`include "pcf_defs.vh"
module pcf_wrap #(
    parameter SMALL = 0
) (
    // Full counter value in
    input wire [12:0] pc_in,
    // Physical word address out
    output wire [12:0] addr_out
);
    wire [12:0] keep_mask;
    genvar i;
    generate
        for (i = 0; i < `PCF_PC_W; i = i + 1) begin : g_mask
            if (SMALL != 0 && i >= `PCF_SMALL_AW) begin : g_drop
                assign keep_mask[i] = 1'b0;
            end else begin : g_keep
                assign keep_mask[i] = 1'b1;
            end
        end
    endgenerate
    assign addr_out = pc_in & keep_mask;
endmodule

/* tb/pcf_imem.sv */
// Purpose: instruction flash model. Assumes: one-cycle read. Notes: idle bus toggles
`timescale 1ns/1ps
module pcf_imem (input clk, input req, input [12:0] addr, output reg [13:0] rdata);
    initial rdata = 14'h0;
    always @(posedge clk) rdata <= req ? {1'b1, addr} : ~rdata;
endmodule

/* tb/pcf_top_asserts.sv */
// Purpose: pcf_top checks. Assumes: one clock. Notes: bound at foot
`timescale 1ns/1ps
module pcf_chk #(parameter SMALL = 0) (input clk, rst, step, branch, irq_take, fetch_req,
    data_req, data_we, data_we_r, insn_valid_r, input [8:0] data_addr_in, data_addr_r,
    input [12:0] branch_addr, pc_r, imem_addr, insn_pc_r, input [13:0] imem_rdata, insn_r);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_RST: assert property (disable iff (1'b0) rst |=> pc_r == 13'h0) else $error("r");
    AST_IRQ: assert property (irq_take |=> pc_r == 13'h4) else $error("i");
    AST_BR: assert property (branch && !irq_take |=> pc_r == $past(branch_addr))
        else $error("b");
    AST_INC: assert property (fetch_req |=> pc_r == $past(pc_r) + 13'h1) else $error("n");
    AST_HOLD: assert property (!(step || branch || irq_take) |=> $stable(pc_r))
        else $error("h");
    AST_WRAP: assert property (imem_addr == (SMALL ? {1'b0, pc_r[11:0]} : pc_r))
        else $error("w");
    AST_FET: assert property (fetch_req |=> ##1 insn_valid_r && insn_pc_r == $past(pc_r, 2)
        && insn_r == $past(imem_rdata)) else $error("f");
    AST_DAT: assert property (data_req |=> data_we_r == $past(data_we)
        && data_addr_r == $past(data_addr_in)) else $error("d");
    cover property (irq_take && branch);
    cover property (fetch_req && pc_r == 13'h1fff);
    cover property (data_req && fetch_req);
endmodule
bind pcf_top pcf_chk #(.SMALL(SMALL)) chk (.clk(clk), .rst(rst), .step(step), .branch(branch),
    .irq_take(irq_take), .fetch_req(fetch_req), .data_req(data_req), .data_we(data_we),
    .data_we_r(data_we_r), .insn_valid_r(insn_valid_r), .data_addr_in(data_addr_in),
    .data_addr_r(data_addr_r), .branch_addr(branch_addr), .pc_r(pc_r), .imem_addr(imem_addr),
    .insn_pc_r(insn_pc_r), .imem_rdata(imem_rdata), .insn_r(insn_r));

/* tb/tb_program_counter_fetch_addressing.sv */
// Purpose: pcf_top bench. Assumes: SMALL=1, full size alongside. Notes: drive 2 ns after edge
`timescale 1ns/1ps
module tb_program_counter_fetch_addressing;
    reg clk = 0, rst = 1, step = 0, branch = 0, irq_take = 0, data_req = 0, data_we = 0;
    reg [12:0] branch_addr = 13'h0;
    reg [8:0] data_addr_in = 9'h0;
    reg [7:0] data_wdata_in = 8'h0;
    wire [12:0] big_addr;
    wire fetch_req, data_req_r, data_we_r, insn_valid_r;
    wire [7:0] data_wdata_r;
    wire [8:0] data_addr_r;
    wire [12:0] imem_addr, pc_r, insn_pc_r;
    wire [13:0] imem_rdata, insn_r;
    integer errors = 0, n_compared = 0;
    pcf_top #(.SMALL(1)) uut (.clk(clk), .rst(rst), .step(step), .branch(branch),
        .branch_addr(branch_addr), .irq_take(irq_take), .data_req(data_req), .data_we(data_we),
        .data_addr_in(data_addr_in), .data_wdata_in(data_wdata_in), .fetch_req(fetch_req),
        .imem_addr(imem_addr), .imem_rdata(imem_rdata), .data_req_r(data_req_r),
        .data_we_r(data_we_r), .data_addr_r(data_addr_r), .data_wdata_r(data_wdata_r),
        .insn_r(insn_r), .insn_valid_r(insn_valid_r), .pc_r(pc_r), .insn_pc_r(insn_pc_r));
    // Full-size variant on the same stimulus, for the unwrapped address path
    pcf_top #(.SMALL(0)) uut_big (.clk(clk), .rst(rst), .step(step), .branch(branch),
        .branch_addr(branch_addr), .irq_take(irq_take), .data_req(data_req), .data_we(data_we),
        .data_addr_in(data_addr_in), .data_wdata_in(data_wdata_in), .fetch_req(),
        .imem_addr(big_addr), .imem_rdata(imem_rdata), .data_req_r(), .data_we_r(),
        .data_addr_r(), .data_wdata_r(), .insn_r(), .insn_valid_r(), .pc_r(), .insn_pc_r());
    pcf_imem mem (.clk(clk), .req(fetch_req), .addr(imem_addr), .rdata(imem_rdata));
    initial forever #10 clk = ~clk;
    task chk(input string nm, input logic [13:0] e, g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task tally_and_finish;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task t_rst;
        rst = 1;
        cyc(10);
        chk("pc", 14'h0, pc_r);
        chk("iv", 14'h0, insn_valid_r);
        rst = 0;
    endtask
    task t_run;
        step = 1;
        cyc(2);
        chk("pc", 14'h2, pc_r);
        chk("in", 14'h2000, insn_r);
        chk("iv", 14'h1, insn_valid_r);
        chk("ip", 14'h0, insn_pc_r);
    endtask
    task t_wrap;
        branch = 1;
        branch_addr = 13'h1fff;
        cyc(1);
        branch = 0;
        chk("ad", 14'hfff, imem_addr);
        chk("ab", 14'h1fff, big_addr);
        cyc(1);
        chk("pc", 14'h0, pc_r);
        chk("iv", 14'h0, insn_valid_r);
        step = 0;
        cyc(1);
        chk("in", 14'h2fff, insn_r);
        chk("ip", 14'h1fff, insn_pc_r);
    endtask
    task t_irq;
        irq_take = 1;
        branch = 1;
        step = 1;
        #1 chk("fr", 14'h0, fetch_req);
        cyc(1);
        irq_take = 0;
        branch = 0;
        chk("pc", 14'h4, pc_r);
    endtask
    task t_data;
        data_req = 1;
        data_we = 1;
        data_addr_in = 9'h1ff;
        data_wdata_in = 8'h5a;
        cyc(1);
        data_req = 0;
        step = 0;
        chk("da", 14'h1ff, data_addr_r);
        chk("pc", 14'h5, pc_r);
        chk("dq", 14'h1, data_req_r);
        chk("dw", 14'h1, data_we_r);
        chk("dd", 14'h5a, data_wdata_r);
        cyc(1);
        chk("dq", 14'h0, data_req_r);
        chk("dw", 14'h0, data_we_r);
        chk("in", 14'h2004, insn_r);
        chk("ip", 14'h4, insn_pc_r);
    endtask
    initial begin
        t_rst;
        t_run;
        t_wrap;
        t_irq;
        t_data;
        t_rst;
        tally_and_finish;
    end
    initial begin
        #50000;
        errors++;
        tally_and_finish;
    end
endmodule
